// ==== core/wkp_pkg.sv ====
package wkp_pkg;

  // ==========================================================
  // bus and frame geometry
  localparam int ADDR_W    = 8;
  localparam int DATA_W    = 16;
  localparam int NUM_PAT   = 2;
  localparam int MASK_REGS = 4;
  localparam int MASK_BYTES = 64;
  localparam int CNT_W     = 7;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_DETECT_ENABLE   = 8'h2a;
  localparam logic [7:0] OFS_MATCH_STATUS    = 8'h70;
  localparam logic [7:0] OFS_P0_CRC_LOW      = 8'h30;
  localparam logic [7:0] OFS_P0_CRC_HIGH     = 8'h32;
  localparam logic [7:0] OFS_P0_MASK_1_16    = 8'h34;
  localparam logic [7:0] OFS_P0_MASK_17_32   = 8'h36;
  localparam logic [7:0] OFS_P0_MASK_33_48   = 8'h38;
  localparam logic [7:0] OFS_P0_MASK_49_64   = 8'h3a;
  localparam logic [7:0] OFS_P1_CRC_LOW      = 8'h40;
  localparam logic [7:0] OFS_P1_CRC_HIGH     = 8'h42;
  localparam logic [7:0] OFS_P1_MASK_1_16    = 8'h44;
  localparam logic [7:0] OFS_P1_MASK_17_32   = 8'h46;
  localparam logic [7:0] OFS_P1_MASK_33_48   = 8'h48;
  localparam logic [7:0] OFS_P1_MASK_49_64   = 8'h4a;

  // ==========================================================
  // field positions and reset values
  localparam int P0_ENABLE_BIT = 0;
  localparam int P1_ENABLE_BIT = 1;
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [1:0]  RST_FLAGS = 2'h0;

  // ==========================================================
  // ethernet crc, reflected form
  localparam logic [31:0] CRC_INIT    = 32'hffff_ffff;
  localparam logic [31:0] CRC_POLY_RF = 32'hedb8_8320;
  localparam logic [31:0] CRC_XOROUT  = 32'hffff_ffff;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    WKP_FLD_CRC_LOW,
    WKP_FLD_CRC_HIGH,
    WKP_FLD_MASK0,
    WKP_FLD_MASK1,
    WKP_FLD_MASK2,
    WKP_FLD_MASK3
  } wkp_fld_e;

  typedef struct packed {
    logic       hit;
    logic       pat;
    wkp_fld_e   fld;
  } wkp_dec_s;

  typedef struct packed {
    logic       valid;
    logic       first;
    logic       last;
    logic [7:0] data;
  } wkp_rx_byte_s;

  typedef struct packed {
    logic [15:0] crc_high;
    logic [15:0] crc_low;
    logic [63:0] mask;
  } wkp_pat_cfg_s;

endpackage

// ==== core/wkp_regs.sv ====
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module wkp_regs (
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic [7:0]             ADDR,
  input  wire logic [15:0]            WDATA,
  input  wire logic                   WR,
  input  wire logic                   RD,
  output logic      [15:0]            RDATA,
  input  wire wkp_pkg::wkp_rx_byte_s  RX,
  output logic      [1:0]             MATCH,
  output logic      [1:0]             DETECT_ENABLE
);

  // ==========================================================
  // helpers
  function automatic wkp_pkg::wkp_dec_s wkp_decode(
    input logic [7:0] a
  );
    wkp_pkg::wkp_dec_s d;
    d = '{hit: 1'b1, pat: 1'b0, fld: wkp_pkg::WKP_FLD_CRC_LOW};
    case (a)
      wkp_pkg::OFS_P0_CRC_LOW: begin
        d.fld = wkp_pkg::WKP_FLD_CRC_LOW;
      end
      wkp_pkg::OFS_P0_CRC_HIGH: begin
        d.fld = wkp_pkg::WKP_FLD_CRC_HIGH;
      end
      wkp_pkg::OFS_P0_MASK_1_16:  d.fld = wkp_pkg::WKP_FLD_MASK0;
      wkp_pkg::OFS_P0_MASK_17_32: d.fld = wkp_pkg::WKP_FLD_MASK1;
      wkp_pkg::OFS_P0_MASK_33_48: d.fld = wkp_pkg::WKP_FLD_MASK2;
      wkp_pkg::OFS_P0_MASK_49_64: d.fld = wkp_pkg::WKP_FLD_MASK3;
      wkp_pkg::OFS_P1_CRC_LOW: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_CRC_LOW;
      end
      wkp_pkg::OFS_P1_CRC_HIGH: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_CRC_HIGH;
      end
      wkp_pkg::OFS_P1_MASK_1_16: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_MASK0;
      end
      wkp_pkg::OFS_P1_MASK_17_32: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_MASK1;
      end
      wkp_pkg::OFS_P1_MASK_33_48: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_MASK2;
      end
      wkp_pkg::OFS_P1_MASK_49_64: begin
        d.pat = 1'b1;
        d.fld = wkp_pkg::WKP_FLD_MASK3;
      end
      // reserved holes and anything else decode to nothing
      default: d.hit = 1'b0;
    endcase
    return d;
  endfunction

  function automatic logic [31:0] wkp_crc_byte(
    input logic [31:0] c,
    input logic [7:0]  b
  );
    logic [31:0] r;
    r = c ^ {24'h00_0000, b};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ wkp_pkg::CRC_POLY_RF) : (r >> 1);
    end
    return r;
  endfunction

  // ==========================================================
  // configuration registers
  wkp_pkg::wkp_pat_cfg_s cfg_reg  [wkp_pkg::NUM_PAT];
  wkp_pkg::wkp_pat_cfg_s cfg_next [wkp_pkg::NUM_PAT];
  logic [1:0]            enable_reg;
  logic [1:0]            enable_next;
  logic [1:0]            status_reg;
  logic [1:0]            status_next;
  logic [15:0]           rdata_reg;
  logic [15:0]           rdata_next;
  logic [1:0]            match_set;
  wkp_pkg::wkp_dec_s     wr_dec;
  wkp_pkg::wkp_dec_s     rd_dec;

  assign wr_dec = wkp_decode(ADDR);
  assign rd_dec = wr_dec;

  always_comb begin
    for (int p = 0; p < wkp_pkg::NUM_PAT; p++) begin
      cfg_next[p] = cfg_reg[p];
    end
    enable_next = enable_reg;
    if (WR && wr_dec.hit) begin
      case (wr_dec.fld)
        wkp_pkg::WKP_FLD_CRC_LOW:
          cfg_next[wr_dec.pat].crc_low = WDATA;
        wkp_pkg::WKP_FLD_CRC_HIGH:
          cfg_next[wr_dec.pat].crc_high = WDATA;
        wkp_pkg::WKP_FLD_MASK0:
          cfg_next[wr_dec.pat].mask[15:0] = WDATA;
        wkp_pkg::WKP_FLD_MASK1:
          cfg_next[wr_dec.pat].mask[31:16] = WDATA;
        wkp_pkg::WKP_FLD_MASK2:
          cfg_next[wr_dec.pat].mask[47:32] = WDATA;
        wkp_pkg::WKP_FLD_MASK3:
          cfg_next[wr_dec.pat].mask[63:48] = WDATA;
        default: ;
      endcase
    end
    if (WR && ADDR == wkp_pkg::OFS_DETECT_ENABLE) begin
      enable_next = {WDATA[wkp_pkg::P1_ENABLE_BIT],
                     WDATA[wkp_pkg::P0_ENABLE_BIT]};
    end
  end

  // sticky match flags: write one to clear, a new match wins
  always_comb begin
    status_next = status_reg;
    if (WR && ADDR == wkp_pkg::OFS_MATCH_STATUS) begin
      status_next = status_reg & ~WDATA[1:0];
    end
    status_next = status_next | match_set;
  end

  // read data only in the cycle after the strobe
  always_comb begin
    rdata_next = 16'h0000;
    if (RD) begin
      if (rd_dec.hit) begin
        case (rd_dec.fld)
          wkp_pkg::WKP_FLD_CRC_LOW:
            rdata_next = cfg_reg[rd_dec.pat].crc_low;
          wkp_pkg::WKP_FLD_CRC_HIGH:
            rdata_next = cfg_reg[rd_dec.pat].crc_high;
          wkp_pkg::WKP_FLD_MASK0:
            rdata_next = cfg_reg[rd_dec.pat].mask[15:0];
          wkp_pkg::WKP_FLD_MASK1:
            rdata_next = cfg_reg[rd_dec.pat].mask[31:16];
          wkp_pkg::WKP_FLD_MASK2:
            rdata_next = cfg_reg[rd_dec.pat].mask[47:32];
          wkp_pkg::WKP_FLD_MASK3:
            rdata_next = cfg_reg[rd_dec.pat].mask[63:48];
          default: rdata_next = 16'h0000;
        endcase
      end else if (ADDR == wkp_pkg::OFS_DETECT_ENABLE) begin
        rdata_next = {14'h0000, enable_reg};
      end else if (ADDR == wkp_pkg::OFS_MATCH_STATUS) begin
        rdata_next = {14'h0000, status_reg};
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      for (int p = 0; p < wkp_pkg::NUM_PAT; p++) begin
        cfg_reg[p] <= '{crc_high: wkp_pkg::RST_REG16,
                        crc_low:  wkp_pkg::RST_REG16,
                        mask:     {4{wkp_pkg::RST_REG16}}};
      end
      enable_reg <= wkp_pkg::RST_FLAGS;
      status_reg <= wkp_pkg::RST_FLAGS;
      rdata_reg  <= wkp_pkg::RST_REG16;
    end else begin
      for (int p = 0; p < wkp_pkg::NUM_PAT; p++) begin
        cfg_reg[p] <= cfg_next[p];
      end
      enable_reg <= enable_next;
      status_reg <= status_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ==========================================================
  // frame matcher
  typedef enum logic {WKP_IDLE, WKP_FRAME} wkp_state_e;

  wkp_state_e  state_reg;
  wkp_state_e  state_next;
  logic [6:0]  cnt_reg;
  logic [6:0]  cnt_next;
  logic [6:0]  cnt_base;
  logic [31:0] crc_reg  [wkp_pkg::NUM_PAT];
  logic [31:0] crc_next [wkp_pkg::NUM_PAT];
  logic [1:0]  match_next;
  logic [1:0]  match_reg;
  logic        take;

  // a byte counts only inside a frame or as its first byte
  assign take     = RX.valid && (RX.first || state_reg == WKP_FRAME);
  assign cnt_base = RX.first ? 7'h00 : cnt_reg;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    if (take) begin
      state_next = RX.last ? WKP_IDLE : WKP_FRAME;
      // saturate: bytes past 64 never enter the crc
      if (cnt_base < 7'(wkp_pkg::MASK_BYTES)) begin
        cnt_next = cnt_base + 7'h01;
      end else begin
        cnt_next = cnt_base;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < wkp_pkg::NUM_PAT; g++) begin : g_pat
      logic [31:0] crc_base;
      logic [31:0] crc_new;
      logic        inc;
      logic [31:0] fcs;

      assign crc_base = RX.first ? wkp_pkg::CRC_INIT : crc_reg[g];
      // mask bit n picks byte n+1 of the frame
      assign inc = (cnt_base < 7'(wkp_pkg::MASK_BYTES)) &&
                   cfg_reg[g].mask[cnt_base[5:0]];
      assign crc_new = inc ? wkp_crc_byte(crc_base, RX.data)
                           : crc_base;
      assign fcs = crc_new ^ wkp_pkg::CRC_XOROUT;

      always_comb begin
        crc_next[g]   = crc_reg[g];
        match_next[g] = 1'b0;
        if (take) begin
          crc_next[g] = crc_new;
          if (RX.last) begin
            match_next[g] = enable_reg[g] &&
              (fcs == {cfg_reg[g].crc_high,
                       cfg_reg[g].crc_low});
          end
        end
      end
    end
  endgenerate

  assign match_set = match_next;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_reg <= WKP_IDLE;
      cnt_reg   <= 7'h00;
      match_reg <= 2'h0;
      for (int p = 0; p < wkp_pkg::NUM_PAT; p++) begin
        crc_reg[p] <= wkp_pkg::CRC_INIT;
      end
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      match_reg <= match_next;
      for (int p = 0; p < wkp_pkg::NUM_PAT; p++) begin
        crc_reg[p] <= crc_next[p];
      end
    end
  end

  // ==========================================================
  // outputs
  assign RDATA         = rdata_reg;
  assign MATCH         = match_reg;
  assign DETECT_ENABLE = enable_reg;

endmodule

`default_nettype wire

// ==== dv/wkp_regs_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module wkp_regs_chk (
  input wire logic                  CLK,
  input wire logic                  RESET_N,
  input wire logic [7:0]            ADDR,
  input wire logic [15:0]           WDATA,
  input wire logic                  WR,
  input wire logic                  RD,
  input wire logic [15:0]           RDATA,
  input wire wkp_pkg::wkp_rx_byte_s RX,
  input wire logic [1:0]            MATCH,
  input wire logic [1:0]            DETECT_ENABLE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  logic en_wr;
  logic rsv;
  assign en_wr = WR && ADDR == wkp_pkg::OFS_DETECT_ENABLE;
  // odd bytes and both reserved holes
  assign rsv = ADDR[7:2] == 6'h0f || ADDR[7:2] == 6'h13 || ADDR[0];
  property p_rd_idle; !RD |=> RDATA == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("data outside slot");
  property p_rsv; RD && rsv |=> RDATA == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("hole read not zero");
  property p_cause; MATCH != 2'h0 |-> $past(RX.valid && RX.last); endproperty
  a_cause: assert property (p_cause) else $error("match without last");
  property p_en0; MATCH[0] |-> $past(DETECT_ENABLE[0]); endproperty
  a_en0: assert property (p_en0) else $error("match0 disabled");
  property p_en1; MATCH[1] |-> $past(DETECT_ENABLE[1]); endproperty
  a_en1: assert property (p_en1) else $error("match1 disabled");
  property p_de_wr; en_wr |=> DETECT_ENABLE == $past(WDATA[1:0]); endproperty
  a_de_wr: assert property (p_de_wr) else $error("enable not written");
  property p_de_hold; !en_wr |=> $stable(DETECT_ENABLE); endproperty
  a_de_hold: assert property (p_de_hold) else $error("enable moved");
  property p_de_rd;
    RD && ADDR == wkp_pkg::OFS_DETECT_ENABLE
      |=> RDATA == {14'h0000, $past(DETECT_ENABLE)};
  endproperty
  a_de_rd: assert property (p_de_rd) else $error("enable readback");
  c_match0: cover property (MATCH[0]);
  c_match1: cover property (MATCH[1]);
  c_rsv: cover property (RD && rsv);
endmodule
bind wkp_regs wkp_regs_chk wkp_regs_chk_i (.CLK(CLK), .RESET_N(RESET_N),
  .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .RX(RX),
  .MATCH(MATCH), .DETECT_ENABLE(DETECT_ENABLE));
`default_nettype wire

// ==== dv/wkp_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module wkp_regs_bench;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic [7:0]            addr = 8'h00;
  logic [15:0]           wdata = 16'h0000;
  logic                  wr = 1'b0;
  logic                  rd = 1'b0;
  logic [15:0]           rdata;
  wkp_pkg::wkp_rx_byte_s rx = '0;
  logic [1:0]            match;
  logic [1:0]            de;
  logic [15:0]           exp_q[$];
  logic [15:0]           got;
  logic [15:0]           exp_v;
  logic                  rd_q = 1'b0;
  logic                  ls_q = 1'b0;
  logic [31:0]           seed = 32'h0000_35da;
  logic [7:0]            frm[70];
  logic [15:0]           v[12];
  logic [63:0]           msk;
  logic [95:0]           cfg;
  logic [7:0]            hole[6] = '{8'h3c, 8'h3e, 8'h4c, 8'h4e, 8'h31, 8'h4b};
  int                    err_total = 0;
  int                    checked = 0;

  always #2.5 clk = ~clk;

  wkp_regs wkp_regs_i (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .RX(rx), .MATCH(match),
    .DETECT_ENABLE(de));

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] ra(int i);
    return 8'(8'h30 + (i / 6) * 16 + (i % 6) * 2);
  endfunction
  // bytes past 64 are never looked at
  function automatic logic [31:0] crc(logic [63:0] m);
    logic [31:0] c;
    c = 32'hffff_ffff;
    for (int i = 0; i < 64; i++) begin
      if (m[i]) begin
        c ^= {24'h00_0000, frm[i]};
        for (int b = 0; b < 8; b++)
          c = c[0] ? (c >> 1) ^ 32'hedb8_8320 : c >> 1;
      end
    end
    return ~c;
  endfunction
  task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
    wr <= w;
    rd <= r;
    addr <= a;
    wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd_chk(logic [7:0] a, logic [15:0] e);
    exp_q.push_back(e);
    bus(1'b0, 1'b1, a, 16'h0000);
  endtask
  task automatic send(logic [1:0] e);
    wr <= 1'b0;
    rd <= 1'b0;
    exp_q.push_back({14'h0000, e});
    for (int i = 0; i < 70; i++) begin
      rx <= '{1'b1, i == 0, i == 69, frm[i]};
      @(posedge clk);
    end
    rx <= '0;
    @(posedge clk);
  endtask
  task automatic conclude();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ==========================================================
  // result watcher: one note per read slot or frame end
  always @(posedge clk) begin
    if (rd_q || ls_q) begin
      got = rd_q ? rdata : {14'h0000, match};
      exp_v = exp_q.pop_front();
      checked++;
      if (got !== exp_v) begin
        err_total++;
        $display("BAD t=%0t exp=%h got=%h", $time, exp_v, got);
      end
    end
    rd_q <= rd;
    ls_q <= rx.valid & rx.last;
  end

  initial begin
    #20000;
    err_total++;
    conclude();
  end

  // ==========================================================
  // tests
  initial begin
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(wkp_pkg::OFS_DETECT_ENABLE, 16'h0000);
    for (int i = 0; i < 12; i++) rd_chk(ra(i), 16'h0000);
    for (int i = 0; i < 12; i++) begin
      v[i] = 16'(rnd());
      bus(1'b1, 1'b0, ra(i), v[i]);
    end
    for (int i = 0; i < 12; i++) rd_chk(ra(i), v[i]);
    $display("test regs done");
    foreach (hole[i]) bus(1'b1, 1'b0, hole[i], 16'hffff);
    foreach (hole[i]) rd_chk(hole[i], 16'h0000);
    for (int i = 0; i < 12; i++) rd_chk(ra(i), v[i]);
    $display("test holes done");
    for (int i = 0; i < 70; i++) frm[i] = 8'(rnd());
    for (int p = 0; p < 2; p++) begin
      msk = {rnd(), rnd()};
      cfg = {msk, crc(msk)};
      for (int k = 0; k < 6; k++) bus(1'b1, 1'b0, ra(6 * p + k), cfg[16*k +: 16]);
    end
    for (int e = 1; e < 4; e++) begin
      bus(1'b1, 1'b0, wkp_pkg::OFS_DETECT_ENABLE, 16'(e));
      rd_chk(wkp_pkg::OFS_DETECT_ENABLE, 16'(e));
      checked++;
      if (de !== e[1:0]) begin
        err_total++;
        $display("BAD t=%0t exp=%h got=%h", $time, e[1:0], de);
      end
      send(e[1:0]);
    end
    // crc high of pattern 1 off by one bit: only pattern 0 may hit
    bus(1'b1, 1'b0, ra(7), 16'h0001 ^ cfg[31:16]);
    send(2'b01);
    rd_chk(wkp_pkg::OFS_MATCH_STATUS, 16'h0003);
    bus(1'b1, 1'b0, wkp_pkg::OFS_MATCH_STATUS, 16'h0003);
    rd_chk(wkp_pkg::OFS_MATCH_STATUS, 16'h0000);
    $display("test frames done");
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd_chk(ra(7), 16'h0000);
    bus(1'b0, 1'b0, 8'h00, 16'h0000);
    @(posedge clk);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
